// File: shared/i2cdm_defs.vh
`ifndef I2CDM_DEFS_VH
`define I2CDM_DEFS_VH
// register byte offsets
`define I2CDM_OFS_DMA_REQ 8'h24
`define I2CDM_OFS_BAUD 8'h28
`define I2CDM_OFS_MASK 8'h2C
`define I2CDM_OFS_RAW 8'h30
`define I2CDM_OFS_MASKED 8'h34
`define I2CDM_OFS_TX_THR 8'h1C
`define I2CDM_OFS_XFER_LEN 8'h38
// dma request control fields
`define I2CDM_BURST_LEN_LSB 8
`define I2CDM_BURST_LEN_MSB 10
`define I2CDM_BURST_EN_BIT 11
// reset values
`define I2CDM_DMA_REQ_RST 32'h0000_0000
`define I2CDM_BAUD_RST 16'h0008
`define I2CDM_MASK_RST 32'h0000_0000
// writable bits of the mask and dma request registers
`define I2CDM_MASK_WMASK 32'h131F_007F
`define I2CDM_DMA_WMASK 32'h0000_0F00
// mask bit positions
`define I2CDM_B_TX_EMPTY 0
`define I2CDM_B_TX_LOW 1
`define I2CDM_B_TX_FULL 2
`define I2CDM_B_TX_OVF 3
`define I2CDM_B_RX_EMPTY 4
`define I2CDM_B_RX_HIGH 5
`define I2CDM_B_RX_FULL 6
`define I2CDM_B_SL_RD_REQ 16
`define I2CDM_B_SL_RD_EMPTY 17
`define I2CDM_B_SL_WR_REQ 18
`define I2CDM_B_M_DONE 19
`define I2CDM_B_S_DONE 20
`define I2CDM_B_ARB_LOST 24
`define I2CDM_B_BUS_FAULT 25
`define I2CDM_B_M_DONE_NS 28
`endif

// File: core/i2cdm_ctrl.v
// Summary of operation
// - burst length used only when burst enabled
// - burst length above remaining transfer gives single requests
// - burst disabled: single one-byte requests
// - burst enabled: burst of burst-length bytes if the 16-entry fifo has room; 32-256 byte lengths give singles
// - remainder of burst transfer by singles
// - 16-bit baud divider, resets to 8
// - bit 0 enables tx empty interrupt
// - bit 1 enables tx low interrupt
// - bit 2 enables tx full interrupt
// - bit 3 enables tx overflow interrupt
// - bit 4 enables rx empty interrupt
// - bit 5 enables rx high interrupt
// - bit 6 enables rx full interrupt
// - bit 16 enables slave read request interrupt
// - bit 17 enables slave read empty interrupt
// - bit 18 enables slave write request interrupt
// - bit 19 enables master done interrupt
// - bit 20 enables slave done interrupt
// - bit 24 enables arbitration lost interrupt
// - bit 25 enables bus fault interrupt
// - bit 28 enables master done no-stop interrupt
// - tx low flag when entries <= threshold
`timescale 1ns/100ps
`include "i2cdm_defs.vh"
module i2cdm_ctrl #(
  parameter CNT_W = 10
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // transmit fifo level and raw event flags from the engine
  input wire [CNT_W-1:0] tx_fifo_count,
  input wire tx_empty_flag,
  input wire tx_full_flag,
  input wire tx_overflow_flag,
  input wire rx_empty_flag,
  input wire rx_high_flag,
  input wire rx_full_flag,
  input wire slave_read_req_flag,
  input wire slave_read_empty_flag,
  input wire slave_write_req_flag,
  input wire master_done_flag,
  input wire slave_done_flag,
  input wire arb_lost_flag,
  input wire bus_fault_flag,
  input wire master_done_nostop_flag,
  // tx dma handshake
  input wire dma_tx_done,
  output reg dma_tx_single_req,
  output reg dma_tx_burst_req,
  // baud divider and interrupt
  output reg [15:0] baud_divider,
  output reg irq
);

  // transmit fifo depth of 16 entries, sized to the room arithmetic
  localparam [CNT_W:0] FIFO_DEPTH = {{(CNT_W-4){1'b0}}, 5'h10};

  reg [31:0] dma_req_q;
  reg [15:0] baud_q;
  reg [31:0] mask_q;
  reg [CNT_W-1:0] tx_level_threshold;
  reg [15:0] xfer_left_q;
  reg busy_q;
  wire req_v = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [31:0] raw_w;
  wire tx_low_flag;
  wire burst_en = dma_req_q[`I2CDM_BURST_EN_BIT];
  wire [2:0] tx_dma_burst_len;
  wire [15:0] burst_bytes;
  wire use_burst;
  wire [CNT_W:0] tx_room;
  reg addr_ok;
  wire [31:0] baud_wr;
  wire [31:0] irq_src;

  // per-source enable bits of the mask register
  wire tx_empty_irq_en = mask_q[`I2CDM_B_TX_EMPTY];
  wire tx_low_irq_en = mask_q[`I2CDM_B_TX_LOW];
  wire tx_full_irq_en = mask_q[`I2CDM_B_TX_FULL];
  wire tx_overflow_irq_en = mask_q[`I2CDM_B_TX_OVF];
  wire rx_empty_irq_en = mask_q[`I2CDM_B_RX_EMPTY];
  wire rx_high_irq_en = mask_q[`I2CDM_B_RX_HIGH];
  wire rx_full_irq_en = mask_q[`I2CDM_B_RX_FULL];
  wire slave_read_req_irq_en = mask_q[`I2CDM_B_SL_RD_REQ];
  wire slave_read_empty_irq_en = mask_q[`I2CDM_B_SL_RD_EMPTY];
  wire slave_write_req_irq_en = mask_q[`I2CDM_B_SL_WR_REQ];
  wire master_done_irq_en = mask_q[`I2CDM_B_M_DONE];
  wire slave_done_irq_en = mask_q[`I2CDM_B_S_DONE];
  wire arb_lost_irq_en = mask_q[`I2CDM_B_ARB_LOST];
  wire bus_fault_irq_en = mask_q[`I2CDM_B_BUS_FAULT];
  wire master_done_nostop_irq_en = mask_q[`I2CDM_B_M_DONE_NS];

  // decoded write strobes, one per writable register
  wire wr_any = req_v & wb_we_i;
  wire wr_dma = wr_any & (wb_adr_i == `I2CDM_OFS_DMA_REQ);
  wire wr_baud = wr_any & (wb_adr_i == `I2CDM_OFS_BAUD);
  wire wr_mask = wr_any & (wb_adr_i == `I2CDM_OFS_MASK);
  wire wr_thr = wr_any & (wb_adr_i == `I2CDM_OFS_TX_THR);
  wire wr_len = wr_any & (wb_adr_i == `I2CDM_OFS_XFER_LEN);

  // merge byte lanes of a write into the old value under a write mask
  function [31:0] lane_wr;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    input [31:0] wm;
    integer i;
    begin
      lane_wr = old;
      for (i = 0; i < 32; i = i + 1) begin
        if (sel[i/8] && wm[i])
          lane_wr[i] = nw[i];
      end
    end
  endfunction

  // burst length code 0..7 maps to 1,4,8,16,32,64,128,256 bytes
  function [15:0] burst_size;
    input [2:0] code;
    begin
      case (code)
        3'h0: burst_size = 16'h0001;
        3'h1: burst_size = 16'h0004;
        3'h2: burst_size = 16'h0008;
        3'h3: burst_size = 16'h0010;
        3'h4: burst_size = 16'h0020;
        3'h5: burst_size = 16'h0040;
        3'h6: burst_size = 16'h0080;
        default: burst_size = 16'h0100;
      endcase
    end
  endfunction

  // tx low flag: at or below threshold
  assign tx_low_flag = (tx_fifo_count <= tx_level_threshold);

  // raw flags arranged like the mask layout
  assign raw_w = {
    3'h0,
    master_done_nostop_flag, // bit 28
    2'h0,
    bus_fault_flag, // bit 25
    arb_lost_flag, // bit 24
    3'h0,
    slave_done_flag, // bit 20
    master_done_flag, // bit 19
    slave_write_req_flag, // bit 18
    slave_read_empty_flag, // bit 17
    slave_read_req_flag, // bit 16
    9'h000,
    rx_full_flag, // bit 6
    rx_high_flag, // bit 5
    rx_empty_flag, // bit 4
    tx_overflow_flag, // bit 3
    tx_full_flag, // bit 2
    tx_low_flag, // bit 1
    tx_empty_flag // bit 0
  };

  // enabled sources; the raw flags themselves stay untouched
  assign irq_src[31:29] = 3'h0;
  assign irq_src[27:26] = 2'h0;
  assign irq_src[23:21] = 3'h0;
  assign irq_src[15:7] = 9'h000;
  assign irq_src[`I2CDM_B_TX_EMPTY] = tx_empty_flag & tx_empty_irq_en;
  assign irq_src[`I2CDM_B_TX_LOW] = tx_low_flag & tx_low_irq_en;
  assign irq_src[`I2CDM_B_TX_FULL] = tx_full_flag & tx_full_irq_en;
  assign irq_src[`I2CDM_B_TX_OVF] =
    tx_overflow_flag & tx_overflow_irq_en;
  assign irq_src[`I2CDM_B_RX_EMPTY] = rx_empty_flag & rx_empty_irq_en;
  assign irq_src[`I2CDM_B_RX_HIGH] = rx_high_flag & rx_high_irq_en;
  assign irq_src[`I2CDM_B_RX_FULL] = rx_full_flag & rx_full_irq_en;
  assign irq_src[`I2CDM_B_SL_RD_REQ] =
    slave_read_req_flag & slave_read_req_irq_en;
  assign irq_src[`I2CDM_B_SL_RD_EMPTY] =
    slave_read_empty_flag & slave_read_empty_irq_en;
  assign irq_src[`I2CDM_B_SL_WR_REQ] =
    slave_write_req_flag & slave_write_req_irq_en;
  assign irq_src[`I2CDM_B_M_DONE] =
    master_done_flag & master_done_irq_en;
  assign irq_src[`I2CDM_B_S_DONE] = slave_done_flag & slave_done_irq_en;
  assign irq_src[`I2CDM_B_ARB_LOST] = arb_lost_flag & arb_lost_irq_en;
  assign irq_src[`I2CDM_B_BUS_FAULT] =
    bus_fault_flag & bus_fault_irq_en;
  assign irq_src[`I2CDM_B_M_DONE_NS] =
    master_done_nostop_flag & master_done_nostop_irq_en;

  // baud write merged in a 32-bit word, low half kept
  assign baud_wr = lane_wr({16'h0000, baud_q}, wb_dat_i, wb_sel_i,
    32'h0000_FFFF);

  // burst length is only looked at with burst enabled
  assign tx_dma_burst_len = burst_en ?
    dma_req_q[`I2CDM_BURST_LEN_MSB:`I2CDM_BURST_LEN_LSB] : 3'h0;
  assign burst_bytes = burst_size(tx_dma_burst_len);
  assign tx_room = FIFO_DEPTH - {1'b0, tx_fifo_count};
  // burst only while a whole burst remains and fits
  wire burst_fits_left = (burst_bytes <= xfer_left_q);
  wire burst_fits_room = ({{(16-CNT_W-1){1'b0}}, tx_room} >= burst_bytes);
  assign use_burst = burst_en && burst_fits_left && burst_fits_room;

  // address decode
  always @* begin
    case (wb_adr_i)
      `I2CDM_OFS_DMA_REQ, `I2CDM_OFS_BAUD, `I2CDM_OFS_MASK,
      `I2CDM_OFS_RAW, `I2CDM_OFS_MASKED, `I2CDM_OFS_TX_THR,
      `I2CDM_OFS_XFER_LEN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // bus acknowledge for mapped addresses, one wait state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req_v & addr_ok;
    end
  end

  // bus error for unmapped addresses, nothing written
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req_v & ~addr_ok;
    end
  end

  // dma request control, only the burst fields are writable
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_req_q <= `I2CDM_DMA_REQ_RST;
    end else if (wr_dma) begin
      dma_req_q <= lane_wr(dma_req_q, wb_dat_i, wb_sel_i, `I2CDM_DMA_WMASK);
    end
  end

  // baud register, low sixteen bits
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_q <= `I2CDM_BAUD_RST;
    end else if (wr_baud) begin
      baud_q <= baud_wr[15:0];
    end
  end

  // interrupt mask, reserved bits stay zero
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= `I2CDM_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= lane_wr(mask_q, wb_dat_i, wb_sel_i, `I2CDM_MASK_WMASK);
    end
  end

  // transmit level threshold
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_level_threshold <= {CNT_W{1'b0}};
    end else if (wr_thr) begin
      tx_level_threshold <= wb_dat_i[CNT_W-1:0];
    end
  end

  // read data, valid only in the ack cycle
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= 32'h0000_0000;
      if (req_v && addr_ok && !wb_we_i) begin
        case (wb_adr_i)
          `I2CDM_OFS_DMA_REQ: wb_dat_o <= dma_req_q;
          `I2CDM_OFS_BAUD: wb_dat_o <= {16'h0000, baud_q};
          `I2CDM_OFS_MASK: wb_dat_o <= mask_q;
          `I2CDM_OFS_RAW: wb_dat_o <= raw_w;
          `I2CDM_OFS_MASKED: wb_dat_o <= irq_src;
          `I2CDM_OFS_TX_THR:
            wb_dat_o <= {{(32-CNT_W){1'b0}}, tx_level_threshold};
          `I2CDM_OFS_XFER_LEN: wb_dat_o <= {16'h0000, xfer_left_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // tx dma request engine; software loads the byte count to move
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      xfer_left_q <= 16'h0000;
      busy_q <= 1'b0;
      dma_tx_single_req <= 1'b0;
      dma_tx_burst_req <= 1'b0;
    end else if (wr_len) begin
      xfer_left_q <= wb_dat_i[15:0];
      busy_q <= 1'b0;
      dma_tx_single_req <= 1'b0;
      dma_tx_burst_req <= 1'b0;
    end else if (busy_q) begin
      // hold request until the dma reports completion
      if (dma_tx_done) begin
        busy_q <= 1'b0;
        dma_tx_single_req <= 1'b0;
        dma_tx_burst_req <= 1'b0;
        if (dma_tx_burst_req)
          xfer_left_q <= xfer_left_q - burst_bytes;
        else
          xfer_left_q <= xfer_left_q - 16'h0001;
      end
    end else if (xfer_left_q != 16'h0000 && !tx_full_flag) begin
      busy_q <= 1'b1;
      if (use_burst)
        dma_tx_burst_req <= 1'b1;
      else
        dma_tx_single_req <= 1'b1;
    end
  end

  // baud divider copy for the bit-rate counter
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_divider <= `I2CDM_BAUD_RST;
    end else begin
      baud_divider <= baud_q;
    end
  end

  // combined interrupt output from enabled sources
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_src;
    end
  end

endmodule // i2cdm_ctrl

// File: verification/i2cdm_chk_chk.sv
`timescale 1ns/100ps
module i2cdm_chk (
  // clock, reset, bus
  input wire ref_clk, arst_n, wb_cyc_i, wb_we_i,
  // watched outputs
  input wire dma_tx_done, dma_tx_single_req, dma_tx_burst_req, irq,
  input wire [15:0] baud_divider
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // a request still waiting for its answer
  sequence s_one; dma_tx_single_req && !dma_tx_done; endsequence
  sequence s_many; dma_tx_burst_req && !dma_tx_done; endsequence
  chk_single_held: assert property (s_one |=> dma_tx_single_req)
    else $error("single dropped early");
  chk_burst_held: assert property (s_many |=> dma_tx_burst_req)
    else $error("burst dropped early");
  chk_single_ends: assert property (
    dma_tx_single_req && dma_tx_done |=> !dma_tx_single_req)
    else $error("single kept after done");
  chk_burst_ends: assert property (
    dma_tx_burst_req && dma_tx_done |=> !dma_tx_burst_req)
    else $error("burst kept after done");
  chk_one_kind: assert property (
    !(dma_tx_single_req && dma_tx_burst_req))
    else $error("both request kinds");
  chk_baud_reset: assert property (
    $rose(arst_n) |-> baud_divider == 16'h0008)
    else $error("baud not 8 after reset");
  chk_baud_hold: assert property (
    !(wb_cyc_i && wb_we_i) [*2] |=> $stable(baud_divider))
    else $error("baud changed unwritten");
  chk_irq_reset: assert property ($rose(arst_n) |-> !irq)
    else $error("irq with reset mask");
endmodule // i2cdm_chk
bind i2cdm_ctrl i2cdm_chk i2cdm_chk_inst (.*);

// File: verification/i2cdm_dma_model.sv
`timescale 1ns/100ps
module i2cdm_dma_model (
  // clock, reset and request handshake
  input wire ref_clk, arst_n, dma_tx_single_req, dma_tx_burst_req,
  output reg dma_tx_done,
  // answered requests of each kind
  output reg [7:0] n_single, n_burst
);
  reg [1:0] wait_q;
  reg slow_q;
  // answer each request, prompt and slow in turn
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {dma_tx_done, n_single, n_burst, wait_q, slow_q} <= 20'h0;
    end else if (dma_tx_done) begin
      dma_tx_done <= 1'b0;
    end else if (dma_tx_single_req || dma_tx_burst_req) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == {slow_q, slow_q}) begin
        dma_tx_done <= 1'b1;
        n_single <= n_single + {7'h0, dma_tx_single_req};
        n_burst <= n_burst + {7'h0, dma_tx_burst_req};
        wait_q <= 2'h0;
        slow_q <= !slow_q;
      end
    end
  end
endmodule // i2cdm_dma_model

// File: verification/i2c_dma_irq_mask_baud_bench.sv
`timescale 1ns/100ps
module i2c_dma_irq_mask_baud_bench;
  reg ref_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0, ef;
  reg [7:0] wb_adr_i = 8'h00, s0, b0;
  reg [3:0] wb_sel_i = 4'hF;
  reg [9:0] tx_fifo_count = 10'h000;
  reg [31:0] wb_dat_i = 32'h0, fl = 32'h0, rd;
  wire [31:0] wb_dat_o;
  wire [15:0] baud_divider;
  wire [7:0] n_s, n_b;
  wire wb_ack_o, wb_err_o, dma_tx_done, dma_tx_single_req, irq;
  wire dma_tx_burst_req;
  integer mismatches = 0, check_count = 0, ticks = 0, i;
  int pos[14] = '{0, 2, 3, 4, 5, 6, 16, 17, 18, 19, 20, 24, 25, 28};
  // design and dma partner
  i2cdm_ctrl i2cdm_ctrl_inst (.*, .tx_empty_flag(fl[0]), .tx_full_flag(fl[2]),
    .tx_overflow_flag(fl[3]), .rx_empty_flag(fl[4]), .rx_high_flag(fl[5]),
    .rx_full_flag(fl[6]), .slave_read_req_flag(fl[16]),
    .slave_read_empty_flag(fl[17]), .slave_write_req_flag(fl[18]),
    .master_done_flag(fl[19]), .slave_done_flag(fl[20]),
    .arb_lost_flag(fl[24]), .bus_fault_flag(fl[25]),
    .master_done_nostop_flag(fl[28]));
  i2cdm_dma_model i2cdm_dma_model_inst (.*, .n_single(n_s), .n_burst(n_b));
  // clock and hang guard
  always #10 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one classic bus cycle, then an idle cycle
  task wb(input w, input [7:0] a, input [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (!(wb_ack_o || wb_err_o));
    rd = wb_dat_o;
    ef = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task t_regs;
    wb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h8, "baud reset");
    wb(1'b1, 8'h28, 32'hFFFF_1234);
    chk({16'h0, baud_divider}, 32'h1234, "baud out");
    wb(1'b1, 8'h2C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h131F_007F, "mask bits");
    wb(1'b0, 8'h00, 32'h0);
    chk({31'h0, ef}, 32'h1, "unmapped");
  endtask
  // each source but tx low alone, masked then enabled
  task t_irq;
    for (i = 0; i < 14; i = i + 1) begin
      fl <= 32'h1 << pos[i];
      wb(1'b1, 8'h2C, ~(32'h1 << pos[i]) & 32'hFFFF_FFFD);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wb(1'b0, 8'h30, 32'h0);
      chk(rd, fl | 32'h2, "raw flags");
      wb(1'b1, 8'h2C, fl);
      chk({31'h0, irq}, 32'h1, "irq enabled");
    end
  endtask
  // tx low flag follows entries against the threshold
  task t_lvl;
    wb(1'b1, 8'h1C, 32'h5);
    tx_fifo_count <= 10'h005;
    wb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h2, "low at threshold");
    wb(1'b1, 8'h2C, 32'h2);
    chk({31'h0, irq}, 32'h1, "low irq on");
    tx_fifo_count <= 10'h006;
    wb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0, "low above threshold");
    chk({31'h0, irq}, 32'h0, "low irq off");
    tx_fifo_count <= 10'h000;
  endtask
  task t_dma(input [11:0] ctl, input [7:0] len, es, eb);
    s0 = n_s;
    b0 = n_b;
    wb(1'b1, 8'h24, {20'h0, ctl});
    wb(1'b1, 8'h38, {24'h0, len});
    do wb(1'b0, 8'h38, 32'h0); while (rd !== 32'h0);
    repeat (4) @(posedge ref_clk);
    chk({24'h0, n_s - s0}, {24'h0, es}, "singles");
    chk({24'h0, n_b - b0}, {24'h0, eb}, "bursts");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_irq;
    fl <= 32'h0;
    t_lvl;
    t_dma(12'h700, 8'h03, 8'h03, 8'h00);
    t_dma(12'h900, 8'h06, 8'h02, 8'h01);
    t_dma(12'hA00, 8'h05, 8'h05, 8'h00);
    complete_run;
  end
endmodule // i2c_dma_irq_mask_baud_bench
